// ---- rtl/intc_pkg.sv ----
package intc_pkg;
   // Register offsets on the peripheral control block.
   localparam logic [7:0] OFF_EOI       = 8'h22;
   localparam logic [7:0] OFF_POLL      = 8'h24;
   localparam logic [7:0] OFF_POLL_STAT = 8'h26;
   localparam logic [7:0] OFF_MASK      = 8'h28;
   localparam logic [7:0] OFF_PRIO_MASK = 8'h2a;
   localparam logic [7:0] OFF_IN_SERV   = 8'h2c;
   localparam logic [7:0] OFF_REQUEST   = 8'h2e;
   localparam logic [7:0] OFF_STATUS    = 8'h30;
   localparam logic [7:0] OFF_CTL_TMR   = 8'h32;
   localparam logic [7:0] OFF_CTL_D0    = 8'h34;
   localparam logic [7:0] OFF_CTL_D1    = 8'h36;
   localparam logic [7:0] OFF_CTL_X0    = 8'h38;
   localparam logic [7:0] OFF_CTL_X1    = 8'h3a;
   localparam logic [7:0] OFF_CTL_X2    = 8'h3c;
   localparam logic [7:0] OFF_CTL_X3    = 8'h3e;
   // Number of master-mode sources, in fixed default order.
   localparam int NSRC = 7;
   // Source index: timer, dma0, dma1, pin0..pin3.
   localparam int SRC_TMR = 0;
   localparam int SRC_D0  = 1;
   localparam int SRC_D1  = 2;
   localparam int SRC_X0  = 3;
   // Bit positions in the in-service, request and mask views.
   localparam int BIT_TMR = 0;
   localparam int BIT_D0  = 2;
   localparam int BIT_D1  = 3;
   localparam int BIT_X0  = 4;
   // Control word fields.
   localparam int CTL_PR_LSB = 0;
   localparam int CTL_MSK    = 3;
   localparam int CTL_LTM    = 4;
   localparam int CTL_CAS    = 5;
   localparam int CTL_SPECIAL_NESTING_SELECT   = 6;
   // Status word fields.
   localparam int STAT_IRT_LSB = 0;
   localparam int STAT_DMA_HALT_FLAG    = 15;
   // End-of-interrupt and poll fields.
   localparam int EOI_TYPE_BIT = 15;
   localparam int POLL_REQ_BIT = 15;
   // Relocation bit that selects slave mode.
   localparam int RELOC_SLAVE_BIT = 14;
   // Reset values.
   localparam logic [2:0] PRIO_LOWEST = 3'h7;
   localparam logic [2:0] PRM_RESET   = 3'h7;
   // Fixed vector types per source.
   localparam logic [4:0] VEC_TMR = 5'h08;
   localparam logic [4:0] VEC_D0  = 5'h0a;
   localparam logic [4:0] VEC_D1  = 5'h0b;
   localparam logic [4:0] VEC_X0  = 5'h0c;
endpackage : intc_pkg

// ---- rtl/interrupt_controller_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
// Function
// - Lower priority blocked while in service
// - Acknowledge or poll read sets in-service
// - End-of-interrupt or in-service write clears; shared timer bit
// - Timer request bit ORs three timers
// - Pin request bits live, write-ignored, edge-qualified
// - Internal request set on arrival, cleared acknowledged
// - Request writes touch only DMA bits
// - Mask register and control mask shared
// - Priority mask blocks numerically greater levels
// - Priority mask resets to seven
// - DMA halt: set by NMI, cleared return
// - Three timer bits in status raise request
// - Three-bit priority, zero is highest
// - Pin trigger select: level or edge
// - Cascade or nesting disables pins two, three
// - Specific end-of-interrupt carries vector type
// - End-of-interrupt write-only, type bit selects
// - Poll sets in-service, poll status does not
// - Poll word: request flag plus vector
// - Master after reset; relocation bit selects slave
// - Slave mode select in, request, acknowledge out
// - Reset clears modes, lowest priority, all masked
module interrupt_controller_regs
   import intc_pkg::*;
(
   input  wire  logic        ref_clk,
   input  wire  logic        rst_n,
   input  wire  logic        clk_en,
   input  wire  logic [7:0]  reg_addr,
   input  wire  logic        reg_wr,
   input  wire  logic        reg_rd,
   input  wire  logic [15:0] reg_wdata,
   output logic        [15:0] reg_rdata,
   input  wire  logic [2:0]  timer_req,
   input  wire  logic [1:0]  dma_req,
   input  wire  logic        ext_request_line0,
   input  wire  logic        ext_request_line1,
   input  wire  logic        ext_request_line2,
   input  wire  logic        ext_request_line3,
   input  wire  logic        nmi_event,
   input  wire  logic        return_from_handler,
   input  wire  logic        int_ack,
   input  wire  logic [15:0] reloc_reg,
   input  wire  logic        slave_select,
   output logic              cpu_int,
   output logic        [4:0] ack_vector,
   output logic              dma_halt_flag,
   output logic              slave_request,
   output logic              acknowledge_out,
   output logic              slave_mode
);
   import intc_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // State.
   logic [NSRC-1:0] in_service_flag_q;
   logic [1:0]      dma_req_q;
   logic [2:0]      per_timer_request_bits_q;
   logic            dma_halt_flag_q;
   logic [2:0]      prio_mask_q;
   logic [2:0]      priority_field_q [NSRC];
   logic [NSRC-1:0] mask_q;
   logic [3:0]      level_trigger_select_q;
   logic [1:0]      cascade_q;
   logic [1:0]      special_nesting_select_q;
   logic [3:0]      pin_prev_q;
   logic [3:0]      pin_armed_q;
   logic [4:0]      vec_q;

   ////////////////////////////////////////////////////////////////////////
   // Decode.
   wire wr_eoi  = reg_wr && reg_addr == OFF_EOI;
   wire wr_mask = reg_wr && reg_addr == OFF_MASK;
   wire wr_prm  = reg_wr && reg_addr == OFF_PRIO_MASK;
   wire wr_is   = reg_wr && reg_addr == OFF_IN_SERV;
   wire wr_req  = reg_wr && reg_addr == OFF_REQUEST;
   wire wr_stat = reg_wr && reg_addr == OFF_STATUS;
   wire rd_poll = reg_rd && reg_addr == OFF_POLL;
   wire [3:0] pins = {ext_request_line3, ext_request_line2,
                      ext_request_line1, ext_request_line0};
   wire [NSRC-1:0] wr_ctl;
   wire [7:0] ctl_off [NSRC];
   assign ctl_off[0] = OFF_CTL_TMR;
   assign ctl_off[1] = OFF_CTL_D0;
   assign ctl_off[2] = OFF_CTL_D1;
   assign ctl_off[3] = OFF_CTL_X0;
   assign ctl_off[4] = OFF_CTL_X1;
   assign ctl_off[5] = OFF_CTL_X2;
   assign ctl_off[6] = OFF_CTL_X3;
   genvar g;
   for (g = 0; g < NSRC; g++) begin : g_wctl
      assign wr_ctl[g] = reg_wr && reg_addr == ctl_off[g];
   end

   assign slave_mode = reloc_reg[RELOC_SLAVE_BIT];
   // Pins two and three unused in cascade or nesting mode.
   wire pins23_off = |cascade_q || |special_nesting_select_q;

   ////////////////////////////////////////////////////////////////////////
   // Request sources.
   // Timer group bit is the OR of three timers.
   wire timer_group_bit = |per_timer_request_bits_q;
   // Level mode requests while high, edge mode only when armed.
   wire [3:0] pin_req;
   for (g = 0; g < 4; g++) begin : g_pin
      assign pin_req[g] = level_trigger_select_q[g] ? pins[g]
                                                    : pins[g] && pin_armed_q[g];
   end
   wire [3:0] pin_ok = slave_mode ? 4'h0 : {~pins23_off, ~pins23_off, 2'b11};
   wire [NSRC-1:0] raw_req = {pin_req & pin_ok, dma_req_q, timer_group_bit};

   ////////////////////////////////////////////////////////////////////////
   // Priority resolution.
   // Lowest level wins, ties by fixed order; a
   // source must beat every in-service level (an in-service pin zero or one with special nesting need not) and pass the priority mask.
   logic [2:0] is_lvl;
   logic       is_any;
   logic [2:0] best_lvl;
   logic       best_hit;
   logic [2:0] best_src;
   logic [2:0] hi_is_src;
   logic       hi_is_hit;
   always_comb begin
      is_lvl = PRIO_LOWEST;
      is_any = 1'b0;
      hi_is_src = 3'h0;
      hi_is_hit = 1'b0;
      for (int i = 0; i < NSRC; i++) begin
         if (in_service_flag_q[i] && (!hi_is_hit || priority_field_q[i] < is_lvl)) begin
            is_lvl = priority_field_q[i];
            is_any = 1'b1;
            hi_is_src = 3'(i);
            hi_is_hit = 1'b1;
         end
      end
      best_lvl = PRIO_LOWEST;
      best_hit = 1'b0;
      best_src = 3'h0;
      for (int i = 0; i < NSRC; i++) begin
         if (raw_req[i] && !mask_q[i] && priority_field_q[i] <= prio_mask_q
             && (!is_any || priority_field_q[i] < is_lvl
                 || (in_service_flag_q[i] && i >= SRC_X0 && i <= SRC_X0 + 1
                     && special_nesting_select_q[i-SRC_X0]))
             && (!best_hit || priority_field_q[i] < best_lvl)) begin
            best_lvl = priority_field_q[i];
            best_hit = 1'b1;
            best_src = 3'(i);
         end
      end
   end
   wire [4:0] best_vec = (best_src == 3'(SRC_TMR)) ? VEC_TMR : VEC_TMR + 5'(best_src) + 5'h01;
   assign cpu_int = best_hit && !slave_mode;
   // Slave request to external master; acknowledge driven while selected.
   assign slave_request = best_hit && slave_mode;
   assign acknowledge_out = slave_mode && slave_select && int_ack;

   ////////////////////////////////////////////////////////////////////////
   // End-of-interrupt decode.
   // Type bit: nonspecific clears highest in-service bit.
   // Specific carries a vector; timer zero type clears timer bit.
   logic [NSRC-1:0] eoi_clr;
   always_comb begin
      eoi_clr = '0;
      if (wr_eoi) begin
         if (reg_wdata[EOI_TYPE_BIT]) begin
            if (hi_is_hit) eoi_clr[hi_is_src] = 1'b1;
         end else begin
            for (int i = 0; i < NSRC; i++) begin
               if (reg_wdata[4:0] == (i == 0 ? VEC_TMR : VEC_TMR + 5'(i) + 5'h01))
                  eoi_clr[i] = 1'b1;
            end
         end
      end
   end
   // Acknowledge or poll read sets the winner's in-service bit.
   wire take = (int_ack || rd_poll) && best_hit;
   wire [NSRC-1:0] ack_set = take ? (NSRC'(1) << best_src) : '0;

   ////////////////////////////////////////////////////////////////////////
   // In-service, request and status state.
   // Cleared only by end-of-interrupt or software write.
   // Internal requests cleared on acknowledge; set wins over clear.
   // Halt flag: NMI or software sets, return clears.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         in_service_flag_q <= '0;
         dma_req_q <= 2'b00;
         per_timer_request_bits_q <= 3'b000;
         dma_halt_flag_q <= 1'b0;
         vec_q <= 5'h00;
      end else if (clk_en) begin
         if (wr_is)
            in_service_flag_q <= {reg_wdata[BIT_X0 +: 4], reg_wdata[BIT_D1],
                                  reg_wdata[BIT_D0], reg_wdata[BIT_TMR]} | ack_set;
         else
            in_service_flag_q <= (in_service_flag_q & ~eoi_clr) | ack_set;
         // Only DMA bits are writable in the request view.
         if (wr_req)
            dma_req_q <= {reg_wdata[BIT_D1], reg_wdata[BIT_D0]} | dma_req;
         else
            dma_req_q <= (dma_req_q & ~ack_set[SRC_D1:SRC_D0]) | dma_req;
         // Status timer bits each raise a timer request.
         if (wr_stat)
            per_timer_request_bits_q <= reg_wdata[STAT_IRT_LSB +: 3] | timer_req;
         else if (ack_set[SRC_TMR])
            per_timer_request_bits_q <= timer_req;
         else
            per_timer_request_bits_q <= per_timer_request_bits_q | timer_req;
         if (nmi_event || (wr_stat && reg_wdata[STAT_DMA_HALT_FLAG]))
            dma_halt_flag_q <= 1'b1;
         else if (return_from_handler || wr_stat)
            dma_halt_flag_q <= 1'b0;
         if (take) vec_q <= best_vec;
      end
   end
   assign dma_halt_flag = dma_halt_flag_q;
   assign ack_vector = vec_q;

   ////////////////////////////////////////////////////////////////////////
   // Configuration state.
   // One mask bit per source shared by both views.
   // Priority mask loads seven on reset.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         prio_mask_q <= PRM_RESET;
         mask_q <= '1;
         level_trigger_select_q <= 4'h0;
         cascade_q <= 2'b00;
         special_nesting_select_q <= 2'b00;
         for (int i = 0; i < NSRC; i++) priority_field_q[i] <= PRIO_LOWEST;
      end else if (clk_en) begin
         if (wr_prm) prio_mask_q <= reg_wdata[2:0];
         if (wr_mask)
            mask_q <= {reg_wdata[BIT_X0 +: 4], reg_wdata[BIT_D1],
                       reg_wdata[BIT_D0], reg_wdata[BIT_TMR]};
         for (int i = 0; i < NSRC; i++) begin
            if (wr_ctl[i]) begin
               priority_field_q[i] <= reg_wdata[CTL_PR_LSB +: 3];
               mask_q[i] <= reg_wdata[CTL_MSK];
               if (i >= SRC_X0) level_trigger_select_q[i-SRC_X0] <= reg_wdata[CTL_LTM];
               if (i == SRC_X0 || i == SRC_X0 + 1) begin
                  cascade_q[i-SRC_X0] <= reg_wdata[CTL_CAS];
                  special_nesting_select_q[i-SRC_X0] <= reg_wdata[CTL_SPECIAL_NESTING_SELECT];
               end
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Edge arming: a pin rearms only after it was seen low.
   // Acknowledge disarms; a held-high line stays disarmed.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_prev_q <= 4'h0;
         pin_armed_q <= 4'h0;
      end else if (clk_en) begin
         pin_prev_q <= pins;
         for (int i = 0; i < 4; i++) begin
            if (ack_set[SRC_X0+i]) pin_armed_q[i] <= 1'b0;
            else if (pins[i] && !pin_prev_q[i]) pin_armed_q[i] <= 1'b1;
            else if (!pins[i]) pin_armed_q[i] <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read data, returned combinationally in the access cycle.
   // Poll words carry request flag and vector.
   wire [15:0] poll_w = {best_hit, 10'h000, best_vec};
   wire [15:0] is_view = {8'h00, in_service_flag_q[6:3], in_service_flag_q[SRC_D1],
                          in_service_flag_q[SRC_D0], 1'b0, in_service_flag_q[SRC_TMR]};
   wire [15:0] msk_view = {8'h00, mask_q[6:3], mask_q[SRC_D1], mask_q[SRC_D0],
                           1'b0, mask_q[SRC_TMR]};
   wire [15:0] req_view = {8'h00, pin_req, dma_req_q, 1'b0, timer_group_bit};
   logic [15:0] ctl_view;
   always_comb begin
      ctl_view = 16'h0000;
      for (int i = 0; i < NSRC; i++) begin
         if (reg_addr == ctl_off[i]) begin
            ctl_view[CTL_PR_LSB +: 3] = priority_field_q[i];
            ctl_view[CTL_MSK] = mask_q[i];
            if (i >= SRC_X0) ctl_view[CTL_LTM] = level_trigger_select_q[i-SRC_X0];
            if (i == SRC_X0 || i == SRC_X0 + 1) begin
               ctl_view[CTL_CAS] = cascade_q[i-SRC_X0];
               ctl_view[CTL_SPECIAL_NESTING_SELECT] = special_nesting_select_q[i-SRC_X0];
            end
         end
      end
   end
   always_comb begin
      case (reg_addr)
         OFF_POLL, OFF_POLL_STAT: reg_rdata = poll_w;
         OFF_MASK:                reg_rdata = msk_view;
         OFF_PRIO_MASK:           reg_rdata = {13'h0000, prio_mask_q};
         OFF_IN_SERV:             reg_rdata = is_view;
         OFF_REQUEST:             reg_rdata = req_view;
         OFF_STATUS:              reg_rdata = {dma_halt_flag_q, 12'h000, per_timer_request_bits_q};
         default:                 reg_rdata = ctl_view;
      endcase
   end
endmodule : interrupt_controller_regs
`default_nettype wire

// ---- dv/interrupt_controller_regs_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module interrupt_controller_regs_checker
   import intc_pkg::*;
(
   input wire logic        ref_clk,
   input wire logic        rst_n,
   input wire logic        clk_en,
   input wire logic [7:0]  reg_addr,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata,
   input wire logic        nmi_event,
   input wire logic        return_from_handler,
   input wire logic        int_ack,
   input wire logic [15:0] reloc_reg,
   input wire logic        slave_select,
   input wire logic        cpu_int,
   input wire logic        dma_halt_flag,
   input wire logic        acknowledge_out,
   input wire logic        slave_mode
);
   ////////////////////////////////////////////////////////////
   // One clock domain, so every check shares clock and reset.
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // A write only lands when the clock enable lets state move.
   wire wr_en = reg_wr & clk_en;
   slave_sel_a: assert property (slave_mode == reloc_reg[RELOC_SLAVE_BIT])
      else $error("slave mode differs from relocation bit");
   ack_out_a: assert property (acknowledge_out == (slave_mode & slave_select & int_ack))
      else $error("acknowledge output wrong");
   halt_set_a: assert property (nmi_event && clk_en |=> dma_halt_flag)
      else $error("halt not set after nmi");
   halt_clear_a: assert property (return_from_handler && clk_en && !nmi_event &&
      !(wr_en && reg_addr == OFF_STATUS) |=> !dma_halt_flag) else $error("halt not cleared on return");
   eoi_wo_a: assert property (reg_addr == OFF_EOI |-> reg_rdata == 16'h0000)
      else $error("end of interrupt word readable");
   mask_block_a: assert property (!slave_mode && reg_addr == OFF_MASK && reg_rdata[7:2] == 6'h3f
      && reg_rdata[0] |-> !cpu_int) else $error("request passed with all masked");
   prm_write_a: assert property (wr_en && reg_addr == OFF_PRIO_MASK ##1 reg_addr == OFF_PRIO_MASK
      |-> reg_rdata[2:0] == $past(reg_wdata[2:0])) else $error("priority mask not stored");
   mask_share_a: assert property (wr_en && reg_addr == OFF_CTL_D0 ##1 !wr_en ##1 reg_addr == OFF_MASK
      |-> reg_rdata[BIT_D0] == $past(reg_wdata[CTL_MSK], 2)) else $error("mask views differ");
   // Main scenarios that the bench is expected to reach.
   cov_poll_c: cover property (reg_rd && reg_addr == OFF_POLL && reg_rdata[POLL_REQ_BIT]);
   cov_nmi_c: cover property (nmi_event ##1 dma_halt_flag);
   cov_slave_c: cover property (acknowledge_out);
endmodule : interrupt_controller_regs_checker
bind interrupt_controller_regs interrupt_controller_regs_checker u_interrupt_controller_regs_checker (
   .ref_clk, .rst_n, .clk_en, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .nmi_event,
   .return_from_handler, .int_ack, .reloc_reg, .slave_select, .cpu_int, .dma_halt_flag,
   .acknowledge_out, .slave_mode);
`default_nettype wire

// ---- dv/intc_ext_source.sv ----
`timescale 1ns/1ps
`default_nettype none
module intc_ext_source (
   input  wire logic ref_clk,
   input  wire logic rst_n,
   input  wire logic raise,
   input  wire logic int_ack,
   output logic      line_q
);
   ////////////////////////////////////////////////////////////
   // hold until acknowledged.
   // Dropping early would lose an edge request, so only the acknowledge releases it.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) line_q <= 1'b0;
      else if (raise) line_q <= 1'b1;
      else if (int_ack) line_q <= 1'b0;
   end
endmodule : intc_ext_source
`default_nettype wire

// ---- dv/interrupt_controller_regs_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module interrupt_controller_regs_tb_top;
   import intc_pkg::*;
   logic ref_clk, rst_n, clk_en, reg_wr, reg_rd, nmi_event, return_from_handler, int_ack, slave_select, raise;
   logic ext_request_line1, ext_request_line2, ext_request_line3, cpu_int, dma_halt_flag;
   logic slave_request, acknowledge_out, slave_mode;
   logic [7:0]  reg_addr;
   logic [15:0] reg_wdata, reg_rdata, reloc_reg, v;
   logic [2:0]  timer_req;
   logic [1:0]  dma_req;
   logic [4:0]  ack_vector;
   wire         ext_request_line0;
   int          fails, checked, cyc;
   interrupt_controller_regs u_interrupt_controller_regs (.ref_clk, .rst_n, .clk_en, .reg_addr, .reg_wr,
      .reg_rd, .reg_wdata, .reg_rdata, .timer_req, .dma_req, .ext_request_line0, .ext_request_line1,
      .ext_request_line2, .ext_request_line3, .nmi_event, .return_from_handler, .int_ack, .reloc_reg,
      .slave_select, .cpu_int, .ack_vector, .dma_halt_flag, .slave_request, .acknowledge_out, .slave_mode);
   intc_ext_source u_intc_ext_source (.ref_clk, .rst_n, .raise, .int_ack, .line_q(ext_request_line0));
   ////////////////////////////////////////////////////////////
   // Clock at 20 MHz and a cycle ceiling far above the planned run.
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 5000) begin
         fails++;
         report_and_stop();
      end
   end
   ////////////////////////////////////////////////////////////
   // Values are captured at the call, so callers let combinational outputs settle first.
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      checked++;
      if (s !== e) begin
         fails++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk
   task automatic chk1(input logic s, input logic e);
      chk({15'h0000, s}, {15'h0000, e});
   endtask : chk1
   // Each access waits its own falling edge, so strobes are never driven twice in one step.
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(negedge ref_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge ref_clk);
      reg_wr = 1'b0;
   endtask : wr
   task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
      @(negedge ref_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      #1 v = reg_rdata;
      @(negedge ref_clk);
      reg_rd = 1'b0;
      chk(v, e);
   endtask : rdchk
   task automatic report_and_stop();
      if (fails == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : report_and_stop
   ////////////////////////////////////////////////////////////
   // Reset values of every read/write word: masked, lowest priority, no level blocked.
   task automatic t_reset();
      for (int a = 'h28; a <= 'h3e; a += 2)
         rdchk(8'(a), a == 'h28 ? 16'h00fd : a == 'h2a ? 16'h0007 : a >= 'h32 ? 16'h000f : 16'h0000);
   endtask : t_reset
   // Priority, poll, nesting and both end-of-interrupt kinds in one pass.
   task automatic t_prio();
      wr(OFF_CTL_D0, 16'h0005);
      @(negedge ref_clk) dma_req = 2'b01;
      @(negedge ref_clk) dma_req = 2'b00;
      chk1(cpu_int, 1'b1);
      wr(OFF_PRIO_MASK, 16'h0004);
      chk1(cpu_int, 1'b0);
      wr(OFF_PRIO_MASK, 16'h0005);
      chk1(cpu_int, 1'b1);
      rdchk(OFF_POLL_STAT, 16'h800a);
      rdchk(OFF_IN_SERV, 16'h0000);
      rdchk(OFF_POLL, 16'h800a);
      rdchk(OFF_IN_SERV, 16'h0004);
      rdchk(OFF_REQUEST, 16'h0000);
      wr(OFF_CTL_TMR, 16'h0006);
      // Open the priority mask so only the in-service level can hold the timer back.
      wr(OFF_PRIO_MASK, 16'h0007);
      @(negedge ref_clk) timer_req = 3'b010;
      @(negedge ref_clk) timer_req = 3'b000;
      chk1(cpu_int, 1'b0);
      rdchk(OFF_STATUS, 16'h0002);
      rdchk(OFF_REQUEST, 16'h0001);
      wr(OFF_EOI, 16'h8000);
      chk1(cpu_int, 1'b1);
      @(negedge ref_clk) int_ack = 1'b1;
      @(negedge ref_clk) int_ack = 1'b0;
      chk({11'h000, ack_vector}, 16'h0008);
      rdchk(OFF_IN_SERV, 16'h0001);
      wr(OFF_EOI, 16'h0008);
      rdchk(OFF_IN_SERV, 16'h0000);
      wr(OFF_STATUS, 16'h0000);
   endtask : t_prio
   // Mask word and control words share one bit; request writes reach only the channel bits.
   task automatic t_mask();
      rdchk(OFF_MASK, 16'h00f8);
      wr(OFF_CTL_D0, 16'h000d);
      rdchk(OFF_MASK, 16'h00fc);
      wr(OFF_MASK, 16'h00fd);
      rdchk(OFF_CTL_TMR, 16'h000e);
      wr(OFF_REQUEST, 16'hffff);
      rdchk(OFF_REQUEST, 16'h000c);
      wr(OFF_REQUEST, 16'h0000);
      rdchk(OFF_REQUEST, 16'h0000);
   endtask : t_mask
   // Level pin follows the line, edge pin needs a rise, cascade silences pin two.
   task automatic t_pins();
      wr(OFF_CTL_X1, 16'h0010);
      @(negedge ref_clk) ext_request_line1 = 1'b1;
      rdchk(OFF_REQUEST, 16'h0020);
      chk1(cpu_int, 1'b1);
      @(negedge ref_clk) ext_request_line1 = 1'b0;
      rdchk(OFF_REQUEST, 16'h0000);
      wr(OFF_CTL_X0, 16'h0000);
      @(negedge ref_clk) raise = 1'b1;
      @(negedge ref_clk) raise = 1'b0;
      rdchk(OFF_REQUEST, 16'h0010);
      @(negedge ref_clk) int_ack = 1'b1;
      @(negedge ref_clk) int_ack = 1'b0;
      chk({11'h000, ack_vector}, 16'h000c);
      wr(OFF_EOI, 16'h8000);
      wr(OFF_CTL_X0, 16'h0028);
      wr(OFF_CTL_X2, 16'h0010);
      @(negedge ref_clk) ext_request_line2 = 1'b1;
      #1;
      chk1(cpu_int, 1'b0);
      @(negedge ref_clk) ext_request_line2 = 1'b0;
   endtask : t_pins
   // Halt flag from nmi, return and software; then slave mode entry and acknowledge.
   task automatic t_halt_slave();
      @(negedge ref_clk) nmi_event = 1'b1;
      @(negedge ref_clk) nmi_event = 1'b0;
      chk1(dma_halt_flag, 1'b1);
      @(negedge ref_clk) return_from_handler = 1'b1;
      @(negedge ref_clk) return_from_handler = 1'b0;
      chk1(dma_halt_flag, 1'b0);
      wr(OFF_STATUS, 16'h8000);
      chk1(dma_halt_flag, 1'b1);
      @(negedge ref_clk);
      reloc_reg = 16'h4000;
      slave_select = 1'b1;
      int_ack = 1'b1;
      #1;
      chk1(slave_mode, 1'b1);
      chk1(acknowledge_out, 1'b1);
      @(negedge ref_clk);
      int_ack = 1'b0;
      slave_select = 1'b0;
      // In slave mode a pending channel request goes to the master, not to the processor.
      wr(OFF_CTL_D1, 16'h0000);
      wr(OFF_REQUEST, 16'h0008);
      chk1(slave_request, 1'b1);
      chk1(cpu_int, 1'b0);
      wr(OFF_REQUEST, 16'h0000);
      chk1(slave_request, 1'b0);
   endtask : t_halt_slave
   ////////////////////////////////////////////////////////////
   // Main sequence: all inputs defined at time zero, reset held twelve cycles.
   initial begin
      {rst_n, reg_wr, reg_rd, nmi_event, return_from_handler, int_ack, slave_select, raise} = '0;
      {ext_request_line1, ext_request_line2, ext_request_line3, timer_req, dma_req} = '0;
      clk_en = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 16'h0000;
      reloc_reg = 16'h0000;
      repeat (12) @(negedge ref_clk);
      rst_n = 1'b1;
      t_reset();
      t_prio();
      t_mask();
      t_pins();
      t_halt_slave();
      report_and_stop();
   end
endmodule : interrupt_controller_regs_tb_top
`default_nettype wire
